// ### rie_exec.sv
// Contract
// - Byte operands zero-extend; move copies source, leaves flags alone.
// - Add stores sum, updates zero, carry, overflow, sign.
// - Add-with-carry also adds carry flag; updates all four flags.
// - Subtract and subtract-with-borrow store difference; update all four flags.
// - Compare subtracts for flags only; destination unchanged.
// - And stores, test discards; both update zero and sign only.
// - Or and exclusive-or store; update zero and sign only.
// - Relative jump adds twice signed 7-bit offset when condition holds.
// - Absolute jump loads PC from destination operand when condition holds.
// - Four-bit condition selects flag tests; 1111 always, 1110 never.
// - Software interrupt pushes PC, decrements SP, loads vector word.
// - Single-operand words: 1101 top, 7-bit opcode, param, destination.
// - Shift, rotate and immediate counts use field plus one.
// - Right shift replicates sign; carry is last bit out of LSB.
// - Left shift; carry is last bit out of MSB.
// - Rotates wrap bits around; update zero, carry, sign.
// - Add and subtract immediate update zero and sign only.
// - Misc group: 000 complements, 001 negates with full flags.
// - Misc 010 sign-extends low byte; updates zero and sign.
// - Interrupt enable set takes effect one cycle later.
// - Fields 1, 2, 3 clear enable, set carry, clear carry.
// - Carry set and clear touch only the carry flag.
// - Flags mean zero, carry or borrow, signed overflow, sign.
// - Dual-operand words: 4-bit opcode, source field, destination field.
// - SP indirect write pre-decrements, read post-increments; with both in one word, SP only decrements.
// Holds the execute unit and its Wishbone register slave.
// Assumes fetch presents operand values and the next PC with EXEC_I.
`timescale 1ns/1ps
module rie_exec
  import rie_pkg::*;
#(
  parameter int WB_AW = 8
) (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [WB_AW-1:0] ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [3:0] SEL_I,
  input wire logic WE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic EXEC_I,
  input wire logic [15:0] INSTR_I,
  input wire logic [15:0] SRC_I,
  input wire logic SRC_BYTE_I,
  input wire logic SRC_POP_I,
  input wire logic [15:0] DST_I,
  input wire logic DST_BYTE_I,
  input wire logic DST_PUSH_I,
  input wire logic [15:0] PC_I,
  input wire logic [15:0] SP_I,
  input wire logic [15:0] MEM_I,
  output logic [15:0] RESULT_O,
  output logic DST_WE_O,
  output logic [15:0] PC_O,
  output logic [15:0] SP_O,
  output logic STACK_WE_O,
  output logic [15:0] STACK_ADDR_O,
  output logic [15:0] STACK_DATA_O,
  output logic [15:0] FLAGS_O,
  output logic IE_O,
  output logic DONE_O
);
  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic run_q;
  logic z_q, c_q, o_q, s_q, ie_q, ie_pend_q;
  wire go = EXEC_I && run_q;
  wire [3:0] op4 = INSTR_I[15:12];
  wire [6:0] op7 = INSTR_I[15:9];
  wire [3:0] cc = INSTR_I[11:8];
  wire [2:0] prm = INSTR_I[8:6];
  wire [5:0] fld = INSTR_I[5:0];
  wire [3:0] cnt = {1'b0, prm} + CNT_ONE;
  wire is_dual = op4 <= OP_XOR;
  wire is_ctl = op7 == OP_MISC && prm == PRM_CTL;
  wire is_ie_set = is_ctl && fld == FLD_IE_SET;
  wire is_ie_clr = is_ctl && fld == FLD_IE_CLR;
  wire is_cy_set = is_ctl && fld == FLD_CY_SET;
  wire is_cy_clr = is_ctl && fld == FLD_CY_CLR;
  wire is_rel = op4 == OP_JMP && !INSTR_I[7];
  wire is_abs = op4 == OP_JMP && INSTR_I[7] && !INSTR_I[6];
  wire is_int = op4 == OP_CALL && cc == INT_CC && !INSTR_I[7];
  wire is_call = op4 == OP_CALL && INSTR_I[7] && !INSTR_I[6];
  // Byte operands are widened with zeros before any arithmetic
  wire [15:0] src_w = SRC_BYTE_I ? {8'h00, SRC_I[7:0]} : SRC_I;
  wire [15:0] dst_w = DST_BYTE_I ? {8'h00, DST_I[7:0]} : DST_I;

  // ----------------------------------------------------------------
  // Condition test
  // ----------------------------------------------------------------
  function automatic logic cond_f(input logic [3:0] c, input logic z, input logic cy,
                                  input logic s, input logic o);
    logic r;
    r = 1'b0;
    case (c)
      CC_Z: r = z;
      CC_NZ: r = !z;
      CC_C: r = cy;
      CC_NC: r = !cy;
      CC_S: r = s;
      CC_NS: r = !s;
      CC_O: r = o;
      CC_NO: r = !o;
      CC_A: r = !z && !cy;
      CC_BE: r = z || cy;
      CC_G: r = (o == s) && !z;
      CC_GE: r = o == s;
      CC_L: r = o != s;
      CC_LE: r = (o != s) || z;
      CC_ALW: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction
  wire cond_ok = cond_f(cc, z_q, c_q, s_q, o_q);

  // ----------------------------------------------------------------
  // Arithmetic and shifter
  // ----------------------------------------------------------------
  wire [16:0] add_w = {1'b0, dst_w} + {1'b0, src_w} + {16'h0000, op4 == OP_ADC && c_q};
  wire [16:0] sub_w = {1'b0, dst_w} - {1'b0, src_w} - {16'h0000, op4 == OP_SBB && c_q};
  wire [15:0] add_sum = add_w[15:0];
  wire add_cout = add_w[16];
  wire [4:0] back = WORD_BITS - {1'b0, cnt};
  wire [15:0] sar_w = 16'($signed(dst_w) >>> cnt);
  wire [15:0] lsh_w = dst_w << cnt;
  wire [15:0] rotr_w = (dst_w >> cnt) | (dst_w << back);
  wire [15:0] rotl_w = (dst_w << cnt) | (dst_w >> back);
  wire [15:0] rsh1 = dst_w >> (cnt - CNT_ONE);
  wire [15:0] lsh1 = dst_w << (cnt - CNT_ONE);
  wire [15:0] imm_w = {12'h000, cnt};
  wire [15:0] negate_w = 16'h0000 - dst_w;
  wire [15:0] rel_tgt = PC_I + {{8{INSTR_I[6]}}, INSTR_I[6:0], 1'b0};
  wire [15:0] sp_dec = SP_I - SP_STEP;
  wire [15:0] sp_inc = SP_I + SP_STEP;

  logic [15:0] res;
  logic wr, up_zs, up_c, up_o, c_n, o_n;
  always_comb begin
    res = dst_w;
    wr = 1'b0;
    up_zs = 1'b0;
    up_c = 1'b0;
    up_o = 1'b0;
    c_n = c_q;
    o_n = o_q;
    if (is_dual) begin
      wr = op4 != OP_COMPARE && op4 != OP_TST;
      up_zs = op4 != OP_COPY;
      case (op4)
        OP_COPY: res = src_w;
        OP_ADD, OP_ADC: begin
          res = add_sum;
          c_n = add_cout;
          o_n = (dst_w[15] == src_w[15]) && (add_sum[15] != dst_w[15]);
          up_c = 1'b1;
          up_o = 1'b1;
        end
        OP_SUB, OP_SBB, OP_COMPARE: begin
          res = sub_w[15:0];
          c_n = sub_w[16];
          o_n = (dst_w[15] != src_w[15]) && (sub_w[15] != dst_w[15]);
          up_c = 1'b1;
          up_o = 1'b1;
        end
        OP_AND, OP_TST: res = dst_w & src_w;
        OP_OR: res = dst_w | src_w;
        default: res = dst_w ^ src_w;
      endcase
    end else if (op4 == OP_MISC[6:3]) begin
      case (op7)
        OP_SAR: begin
          res = sar_w;
          c_n = rsh1[0];
          {wr, up_zs, up_c} = 3'h7;
        end
        OP_LSHIFT: begin
          res = lsh_w;
          c_n = lsh1[15];
          {wr, up_zs, up_c} = 3'h7;
        end
        OP_ROT_RIGHT: begin
          res = rotr_w;
          c_n = rsh1[0];
          {wr, up_zs, up_c} = 3'h7;
        end
        OP_ROT_LEFT: begin
          res = rotl_w;
          c_n = lsh1[15];
          {wr, up_zs, up_c} = 3'h7;
        end
        OP_ADD_IMM: begin
          res = dst_w + imm_w;
          {wr, up_zs} = 2'h3;
        end
        OP_SUB_IMM: begin
          res = dst_w - imm_w;
          {wr, up_zs} = 2'h3;
        end
        OP_MISC: begin
          if (prm == PRM_NOT) begin
            res = ~dst_w;
            {wr, up_zs} = 2'h3;
          end else if (prm == PRM_NEGATE) begin
            res = negate_w;
            c_n = dst_w != 16'h0000;
            o_n = dst_w[15] && negate_w[15];
            {wr, up_zs, up_c, up_o} = 4'hF;
          end else if (prm == PRM_SEXT) begin
            res = {{8{dst_w[7]}}, dst_w[7:0]};
            {wr, up_zs} = 2'h3;
          end else if (is_cy_set || is_cy_clr) begin
            c_n = is_cy_set;
            up_c = 1'b1;
          end
        end
        default: res = dst_w;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Program flow and stack
  // ----------------------------------------------------------------
  logic [15:0] pc_n, sp_n, stk_addr;
  logic stk_we;
  always_comb begin
    pc_n = PC_I;
    sp_n = SP_I;
    stk_we = 1'b0;
    stk_addr = SP_I;
    if (is_dual) begin
      if (DST_PUSH_I) begin
        sp_n = sp_dec;
      end else if (SRC_POP_I) begin
        sp_n = sp_inc;
      end
    end else if (is_rel && cond_ok) begin
      pc_n = rel_tgt;
    end else if (is_abs && cond_ok) begin
      pc_n = dst_w;
      if (fld == FLD_POP) begin
        sp_n = sp_inc;
      end
    end else if (is_int) begin
      pc_n = MEM_I;
      stk_we = 1'b1;
      sp_n = sp_dec;
    end else if (is_call && cond_ok) begin
      pc_n = dst_w;
      stk_we = 1'b1;
      stk_addr = sp_dec;
      sp_n = sp_dec;
    end
  end

  // ----------------------------------------------------------------
  // Architectural state
  // ----------------------------------------------------------------
  logic [15:0] res_q, pc_q, sp_q, stk_addr_q, stk_data_q;
  logic dst_we_q, stk_we_q, done_q;
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      res_q <= 16'h0000;
      pc_q <= RESET_VECTOR;
      sp_q <= SP_RST;
      stk_addr_q <= 16'h0000;
      stk_data_q <= 16'h0000;
      dst_we_q <= 1'b0;
      stk_we_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= go;
      dst_we_q <= go && wr;
      stk_we_q <= go && stk_we;
      if (go) begin
        res_q <= res;
        pc_q <= pc_n;
        sp_q <= sp_n;
        stk_addr_q <= stk_addr;
        stk_data_q <= PC_I;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      {z_q, c_q, o_q, s_q} <= 4'h0;
    end else if (go) begin
      if (up_zs) begin
        z_q <= res == 16'h0000;
        s_q <= res[15];
      end
      if (up_c) begin
        c_q <= c_n;
      end
      if (up_o) begin
        o_q <= o_n;
      end
    end
  end

  // Enable set is staged so the instruction after it still runs masked
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ie_pend_q <= 1'b0;
      ie_q <= 1'b0;
    end else begin
      ie_pend_q <= go && is_ie_set;
      if (ie_pend_q) begin
        ie_q <= 1'b1;
      end else if (go && is_ie_clr) begin
        ie_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic ack_q;
  logic [31:0] rd_q, rd_d;
  wire req = CYC_I && STB_I && !ack_q;
  always_comb begin
    if (ADR_I == WB_AW'(REG_CTRL)) begin
      rd_d = {31'h00000000, run_q};
    end else if (ADR_I == WB_AW'(REG_STATUS)) begin
      rd_d = {16'h0000, FLAGS_O};
    end else if (ADR_I == WB_AW'(REG_RESULT)) begin
      rd_d = {16'h0000, res_q};
    end else if (ADR_I == WB_AW'(REG_PC)) begin
      rd_d = {sp_q, pc_q};
    end else begin
      rd_d = 32'h00000000;
    end
  end
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ack_q <= 1'b0;
      rd_q <= 32'h00000000;
      run_q <= CTRL_RST;
    end else begin
      ack_q <= req;
      if (req) begin
        rd_q <= rd_d;
      end
      if (ack_q && CYC_I && STB_I && WE_I && SEL_I[0] && ADR_I == WB_AW'(REG_CTRL)) begin
        run_q <= DAT_I[0];
      end
    end
  end

  assign DAT_O = rd_q;
  assign ACK_O = ack_q;
  assign RESULT_O = res_q;
  assign DST_WE_O = dst_we_q;
  assign PC_O = pc_q;
  assign SP_O = sp_q;
  assign STACK_WE_O = stk_we_q;
  assign STACK_ADDR_O = stk_addr_q;
  assign STACK_DATA_O = stk_data_q;
  assign FLAGS_O = {11'h000, ie_q, s_q, o_q, c_q, z_q};
  assign IE_O = ie_q;
  assign DONE_O = done_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence ie_late_s;
    !IE_O ##1 IE_O;
  endsequence
  sequence int_push_s;
    STACK_WE_O && STACK_ADDR_O == $past(SP_I) && STACK_DATA_O == $past(PC_I);
  endsequence
  move_noflags_a: assert property (
    go && op4 == OP_COPY |=> $stable({z_q, c_q, o_q, s_q}) && DST_WE_O)
    else $error("move changed a flag or skipped its write");
  add_result_a: assert property (
    go && op4 == OP_ADD |=> {c_q, RESULT_O} == 17'($past(dst_w)) + 17'($past(src_w)))
    else $error("add result or carry wrong");
  compare_nowrite_a: assert property (
    go && op4 == OP_COMPARE |=> !DST_WE_O)
    else $error("compare wrote its destination");
  rel_jump_a: assert property (
    go && is_rel && cc == CC_ALW |=>
      PC_O == 16'($past(PC_I) + 16'($signed($past(INSTR_I[6:0])) * 2)))
    else $error("relative jump target wrong");
  int_stack_a: assert property (
    go && is_int |=> int_push_s ##0 SP_O == $past(SP_I) - SP_STEP && PC_O == $past(MEM_I))
    else $error("software interrupt stack push wrong");
  ie_delay_a: assert property (
    go && is_ie_set && !ie_q && !ie_pend_q |=> ie_late_s)
    else $error("interrupt enable not one cycle late");
  addimm_keepc_a: assert property (
    go && op7 == OP_ADD_IMM |=> $stable(c_q) && $stable(o_q))
    else $error("add immediate touched carry or overflow");
  carry_set_a: assert property (
    go && is_cy_set |=> c_q && $stable(z_q) && $stable(s_q) && $stable(o_q))
    else $error("carry set failed or touched other flags");
  wb_ack_a: assert property (
    CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
    else $error("bus answer not a single cycle");
endmodule

// ### rie_pkg.sv
// Constants for the 16-bit RISC instruction execute block.
// Assumes a single 40 MHz clock and classic Wishbone register access.
package rie_pkg;
  // ----------------------------------------------------------------
  // Instruction fields and opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_COPY = 4'h0;
  localparam logic [3:0] OP_ADD = 4'h1;
  localparam logic [3:0] OP_ADC = 4'h2;
  localparam logic [3:0] OP_SUB = 4'h3;
  localparam logic [3:0] OP_SBB = 4'h4;
  localparam logic [3:0] OP_COMPARE = 4'h5;
  localparam logic [3:0] OP_AND = 4'h6;
  localparam logic [3:0] OP_TST = 4'h7;
  localparam logic [3:0] OP_OR = 4'h8;
  localparam logic [3:0] OP_XOR = 4'h9;
  localparam logic [3:0] OP_CALL = 4'hA;
  localparam logic [3:0] OP_JMP = 4'hC;
  localparam logic [6:0] OP_SAR = 7'h68;
  localparam logic [6:0] OP_LSHIFT = 7'h69;
  localparam logic [6:0] OP_ROT_RIGHT = 7'h6A;
  localparam logic [6:0] OP_ROT_LEFT = 7'h6B;
  localparam logic [6:0] OP_ADD_IMM = 7'h6C;
  localparam logic [6:0] OP_SUB_IMM = 7'h6D;
  localparam logic [6:0] OP_MISC = 7'h6F;
  localparam logic [2:0] PRM_NOT = 3'h0;
  localparam logic [2:0] PRM_NEGATE = 3'h1;
  localparam logic [2:0] PRM_SEXT = 3'h2;
  localparam logic [2:0] PRM_CTL = 3'h7;
  localparam logic [5:0] FLD_IE_SET = 6'h00;
  localparam logic [5:0] FLD_IE_CLR = 6'h01;
  localparam logic [5:0] FLD_CY_SET = 6'h02;
  localparam logic [5:0] FLD_CY_CLR = 6'h03;
  localparam logic [5:0] FLD_POP = 6'h17;
  localparam logic [3:0] INT_CC = 4'h0;
  // ----------------------------------------------------------------
  // Condition codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CC_Z = 4'h0;
  localparam logic [3:0] CC_NZ = 4'h1;
  localparam logic [3:0] CC_C = 4'h2;
  localparam logic [3:0] CC_NC = 4'h3;
  localparam logic [3:0] CC_S = 4'h4;
  localparam logic [3:0] CC_NS = 4'h5;
  localparam logic [3:0] CC_O = 4'h6;
  localparam logic [3:0] CC_NO = 4'h7;
  localparam logic [3:0] CC_A = 4'h8;
  localparam logic [3:0] CC_BE = 4'h9;
  localparam logic [3:0] CC_G = 4'hA;
  localparam logic [3:0] CC_GE = 4'hB;
  localparam logic [3:0] CC_L = 4'hC;
  localparam logic [3:0] CC_LE = 4'hD;
  localparam logic [3:0] CC_ALW = 4'hF;
  // ----------------------------------------------------------------
  // Registers, resets and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0C;
  localparam logic CTRL_RST = 1'b1;
  localparam logic [15:0] RESET_VECTOR = 16'hFFF0;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] SP_STEP = 16'h0002;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [4:0] WORD_BITS = 5'h10;
endpackage

// ### rie_prog_mem.sv
// Program memory model facing the execute block.
// Assumes byte addresses; the word pattern is fixed per address.
`timescale 1ns/1ps
module rie_prog_mem (
  input wire logic [15:0] addr_i,
  output logic [15:0] data_o
);
  // ----------------------------------------------------------------
  // Word lookup
  // ----------------------------------------------------------------
  // Pattern differs per address so a wrongly scaled vector is seen
  assign data_o = {addr_i[7:0] ^ 8'hA5, addr_i[15:8]};
endmodule

// ### risc16_instruction_execute_test.sv
// Testbench for the execute block with its Wishbone register slave.
// Assumes one 40 MHz clock and a memory model for vector fetches.
`timescale 1ns/1ps
module risc16_instruction_execute_test
  import rie_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic ex = 1'b0;
  logic [15:0] ins = 16'h0;
  logic [15:0] src = 16'h0;
  logic [15:0] dst = 16'h0;
  logic [2:0] opt = 3'h0;
  logic dbyte = 1'b0;
  logic [15:0] pc_in = 16'h0100;
  logic [15:0] sp_in = 16'h0800;
  logic [31:0] rd;
  logic ack;
  logic [15:0] mem;
  logic [15:0] res;
  logic dwe;
  logic [15:0] pc;
  logic [15:0] sp;
  logic swe;
  logic [15:0] sadr;
  logic [15:0] sdat;
  logic [15:0] flg;
  logic ie;
  logic done;
  logic [31:0] q;
  logic [15:0] taken = 16'h8D5A;
  int mismatches = 0;
  int n_checks = 0;

  rie_exec u_rie_exec (
    .REF_CLK_I(clk), .RESET_N_I(rst_n), .ADR_I(adr), .DAT_I(wd),
    .SEL_I(4'hF), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(rd),
    .ACK_O(ack), .EXEC_I(ex), .INSTR_I(ins), .SRC_I(src),
    .SRC_BYTE_I(opt[0]), .SRC_POP_I(opt[2]), .DST_I(dst),
    .DST_BYTE_I(dbyte), .DST_PUSH_I(opt[1]), .PC_I(pc_in), .SP_I(sp_in),
    .MEM_I(mem), .RESULT_O(res), .DST_WE_O(dwe), .PC_O(pc), .SP_O(sp),
    .STACK_WE_O(swe), .STACK_ADDR_O(sadr), .STACK_DATA_O(sdat),
    .FLAGS_O(flg), .IE_O(ie), .DONE_O(done)
  );
  // Vector table lives at twice the vector number
  rie_prog_mem u_rie_prog_mem (
    .addr_i({8'h00, ins[6:0], 1'b0}),
    .data_o(mem)
  );

  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Classic single cycle; waits for ack, released at the sampling edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) mismatches++;
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic run(input logic [15:0] i, input logic [15:0] s, input logic [15:0] d,
                     input logic [2:0] o);
    int n;
    n = 0;
    @(posedge clk);
    ins <= i;
    src <= s;
    dst <= d;
    opt <= o;
    ex <= 1'b1;
    @(posedge clk);
    ex <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20) mismatches++;
  endtask

  task automatic alu(input logic [15:0] i, input logic [15:0] s, input logic [15:0] d,
                     input logic [15:0] r, input logic [15:0] f, input logic w);
    run(i, s, d, {2'b00, i == 16'h0000 && s == 16'h12AB});
    chk("res", res, r);
    chk("flags", flg, f);
    chk("dst_we", dwe, w);
    chk("pc", pc, pc_in);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #(25 * 6000);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("pc_rst", pc, RESET_VECTOR);
    chk("sp_rst", sp, SP_RST);
    chk("flags_rst", flg, 16'h0000);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", q, {31'h0, CTRL_RST});
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", q, 32'h0);
    // Byte destination: upper byte must be dropped before the add
    @(posedge clk);
    dbyte <= 1'b1;
    alu(16'h1000, 16'h0001, 16'hAB80, 16'h0081, 16'h0000, 1'b1);
    @(posedge clk);
    dbyte <= 1'b0;
    alu(16'hDFC2, 16'h0, 16'h0, 16'h0, 16'h0002, 1'b0);
    alu(16'h0000, 16'h1234, 16'h5555, 16'h1234, 16'h0002, 1'b1);
    alu(16'h2000, 16'h0001, 16'h0001, 16'h0003, 16'h0000, 1'b1);
    alu(16'h1000, 16'hFFFF, 16'h0001, 16'h0000, 16'h0003, 1'b1);
    alu(16'h4000, 16'h0001, 16'h0005, 16'h0003, 16'h0000, 1'b1);
    alu(16'h3000, 16'h0002, 16'h0001, 16'hFFFF, 16'h000A, 1'b1);
    alu(16'h5000, 16'h0001, 16'h8000, 16'h7FFF, 16'h0004, 1'b0);
    alu(16'h6000, 16'h0FF0, 16'hF0F0, 16'h00F0, 16'h0004, 1'b1);
    alu(16'h7000, 16'h8000, 16'h8000, 16'h8000, 16'h000C, 1'b0);
    alu(16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0005, 1'b1);
    alu(16'h9000, 16'h00FF, 16'hFFFF, 16'hFF00, 16'h000C, 1'b1);
    alu(16'h0000, 16'h12AB, 16'h0000, 16'h00AB, 16'h000C, 1'b1);
    alu(16'hD040, 16'h0, 16'h8005, 16'hE001, 16'h000C, 1'b1);
    alu(16'hD200, 16'h0, 16'h8001, 16'h0002, 16'h0006, 1'b1);
    alu(16'hD400, 16'h0, 16'h0001, 16'h8000, 16'h000E, 1'b1);
    alu(16'hD7C0, 16'h0, 16'h1234, 16'h3412, 16'h0004, 1'b1);
    alu(16'hD9C0, 16'h0, 16'hFFF8, 16'h0000, 16'h0005, 1'b1);
    alu(16'hDA00, 16'h0, 16'h0000, 16'hFFFF, 16'h000C, 1'b1);
    alu(16'hDE00, 16'h0, 16'h00FF, 16'hFF00, 16'h000C, 1'b1);
    alu(16'hDE40, 16'h0, 16'h8000, 16'h8000, 16'h000E, 1'b1);
    alu(16'hDE80, 16'h0, 16'h0080, 16'hFF80, 16'h000E, 1'b1);
    wb(1'b1, REG_STATUS, 32'h0);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("status", q, 32'h000E);
    wb(1'b0, REG_RESULT, 32'h0);
    chk("result_reg", q, 32'h0000FF80);
    wb(1'b0, REG_PC, 32'h0);
    chk("pc_reg", q, 32'h08000100);
    // Halted core must ignore a request outright
    wb(1'b1, REG_CTRL, 32'h0);
    @(posedge clk);
    ins <= 16'h1000;
    ex <= 1'b1;
    @(posedge clk);
    ex <= 1'b0;
    #1;
    chk("halt_done", done, 1'b0);
    chk("halt_res", res, 16'hFF80);
    wb(1'b1, REG_CTRL, 32'h1);
    alu(16'hDFC3, 16'h0, 16'h0, 16'h0, 16'h000C, 1'b0);
    for (int i = 0; i < 16; i++) begin
      run(16'hC07F | 16'(i << 8), 16'h0, 16'h0, 3'h0);
      chk("rel_pc", pc, taken[i] ? 16'h00FE : 16'h0100);
    end
    run(16'hCF3F, 16'h0, 16'h0, 3'h0);
    chk("rel_max", pc, 16'h017E);
    run(16'hCF87, 16'h0, 16'h4000, 3'h0);
    chk("abs_pc", pc, 16'h4000);
    run(16'hCF97, 16'h0, 16'h2222, 3'h0);
    chk("ret_pc", pc, 16'h2222);
    chk("ret_sp", sp, 16'h0802);
    run(16'hAF87, 16'h0, 16'h3000, 3'h0);
    chk("call_we", swe, 1'b1);
    chk("call", {sadr, sdat}, {16'h07FE, 16'h0100});
    chk("call_pc_sp", {pc, sp}, {16'h3000, 16'h07FE});
    run(16'hA025, 16'h0, 16'h0, 3'h0);
    chk("int_we", swe, 1'b1);
    chk("int", {sadr, sdat}, {16'h0800, 16'h0100});
    chk("int_pc_sp", {pc, sp}, {16'hEF00, 16'h07FE});
    run(16'h0000, 16'h0001, 16'h0, 3'b010);
    chk("push_sp", sp, 16'h07FE);
    run(16'h0000, 16'h0001, 16'h0, 3'b100);
    chk("pop_sp", sp, 16'h0802);
    run(16'hDFC0, 16'h0, 16'h0, 3'h0);
    chk("ie_early", ie, 1'b0);
    @(posedge clk);
    #1;
    chk("ie_set", ie, 1'b1);
    run(16'hDFC1, 16'h0, 16'h0, 3'h0);
    @(posedge clk);
    #1;
    chk("ie_clr", {ie, flg}, {1'b0, 16'h000C});
    // Zero flag is clear here, so condition 0000 must not be taken
    run(16'hC087, 16'h0, 16'h4000, 3'h0);
    chk("abs_skip", {pc, sp}, {16'h0100, 16'h0800});
    run(16'hC097, 16'h0, 16'h2222, 3'h0);
    chk("ret_skip", {pc, sp}, {16'h0100, 16'h0800});
    run(16'hA087, 16'h0, 16'h3000, 3'h0);
    chk("call_skip_we", swe, 1'b0);
    chk("call_skip", {pc, sp}, {16'h0100, 16'h0800});
    stop_test();
  end
endmodule
